// ### hw/bcc_pkg_bitmap.sv
// Shared constants, decode helpers and the bit-address mapper
`timescale 1ns/1ps
//
// Contract
// - Carry-AND-bit: opcode 1000_0010 plus bit address, two bytes, two cycles.
// - Carry-AND-inverted-bit: opcode 1011_0000, two bytes, two cycles, bit kept.
// - Compare branches only on mismatch, target is advanced PC plus signed offset.
// - Carry set when first operand unsigned-less than second, else cleared.
// - Four compare pairings: A/direct, A/immediate, register/immediate, indirect/immediate.
// - A-versus-direct compare: 1011_0101, three bytes, two cycles, PC plus three.
// - A-versus-immediate compare: 1011_0100, three bytes, two cycles.
// - Register-versus-immediate compare: 1011_1rrr selects one of eight registers.
// - Indirect-versus-immediate compare: 1011_011i, RAM byte at pointer, three bytes.
// - Clear accumulator: 1110_0100, one byte, one cycle, no flag changes.
// - Clear bit: 1100_0011 for carry, 1100_0010 plus bit address, one cycle.
// - Clear accepts the carry or any directly addressable bit.
// - Carry-AND clears carry when source is zero, else leaves it alone.

package bcc_pkg;

  // Opcodes of this instruction group
  localparam logic [7:0] OPC_AND_BIT  = 8'h82;
  localparam logic [7:0] OPC_AND_NBIT = 8'hB0;
  localparam logic [7:0] OPC_CJ_DIR   = 8'hB5;
  localparam logic [7:0] OPC_CJ_IMM   = 8'hB4;
  localparam logic [7:0] OPC_CJ_IND   = 8'hB6;
  localparam logic [7:0] OPC_CJ_REG   = 8'hB8;
  localparam logic [7:0] OPC_CLR_A    = 8'hE4;
  localparam logic [7:0] OPC_CLR_C    = 8'hC3;
  localparam logic [7:0] OPC_CLR_BIT  = 8'hC2;

  // Masks for opcodes that carry a register index
  localparam logic [7:0] MASK_IND     = 8'hFE;
  localparam logic [7:0] MASK_REG     = 8'hF8;

  // Bit-addressable space layout
  localparam logic [7:0] BIT_SFR_LIMIT = 8'h80;
  localparam logic [7:0] BIT_RAM_BASE  = 8'h20;

  // Timing: core clock and clocks per machine cycle
  localparam int         CLK_HZ      = 50_000_000;
  localparam int         MC_CLKS     = 12;
  localparam logic [3:0] MC_LAST     = 4'(MC_CLKS - 1);

  // Reset values
  localparam logic [7:0]  BYTE_RST   = 8'h00;
  localparam logic [15:0] PC_RST     = 16'h0000;

  // Operation kinds of the group
  typedef enum logic [3:0]
  {
    BCC_OP_NONE     = 4'h0,
    BCC_OP_AND_BIT  = 4'h1,
    BCC_OP_AND_NBIT = 4'h2,
    BCC_OP_CJ_DIR   = 4'h3,
    BCC_OP_CJ_IMM   = 4'h4,
    BCC_OP_CJ_REG   = 4'h5,
    BCC_OP_CJ_IND   = 4'h6,
    BCC_OP_CLR_A    = 4'h7,
    BCC_OP_CLR_C    = 4'h8,
    BCC_OP_CLR_BIT  = 4'h9
  } bcc_op_t;

  // Opcode decode, shared by claim logic and the executer
  function automatic bcc_op_t bcc_decode(input logic [7:0] opc);
    bcc_op_t op;
    op = BCC_OP_NONE;
    if (opc == OPC_AND_BIT)
      op = BCC_OP_AND_BIT;
    else if (opc == OPC_AND_NBIT)
      op = BCC_OP_AND_NBIT;
    else if (opc == OPC_CJ_DIR)
      op = BCC_OP_CJ_DIR;
    else if (opc == OPC_CJ_IMM)
      op = BCC_OP_CJ_IMM;
    else if ((opc & MASK_REG) == OPC_CJ_REG)
      op = BCC_OP_CJ_REG;
    else if ((opc & MASK_IND) == OPC_CJ_IND)
      op = BCC_OP_CJ_IND;
    else if (opc == OPC_CLR_A)
      op = BCC_OP_CLR_A;
    else if (opc == OPC_CLR_C)
      op = BCC_OP_CLR_C;
    else if (opc == OPC_CLR_BIT)
      op = BCC_OP_CLR_BIT;
    return op;
  endfunction

  // Instruction length in bytes
  function automatic logic [1:0] bcc_len(input bcc_op_t op);
    logic [1:0] n;
    n = 2'd1;
    if (op == BCC_OP_AND_BIT || op == BCC_OP_AND_NBIT
        || op == BCC_OP_CLR_BIT)
      n = 2'd2;
    else if (op == BCC_OP_CJ_DIR || op == BCC_OP_CJ_IMM
             || op == BCC_OP_CJ_REG || op == BCC_OP_CJ_IND)
      n = 2'd3;
    return n;
  endfunction

  // Machine cycles per instruction
  function automatic logic [1:0] bcc_cycles(input bcc_op_t op);
    logic [1:0] n;
    n = 2'd1;
    if (op == BCC_OP_AND_BIT || op == BCC_OP_AND_NBIT
        || op == BCC_OP_CJ_DIR || op == BCC_OP_CJ_IMM
        || op == BCC_OP_CJ_REG || op == BCC_OP_CJ_IND)
      n = 2'd2;
    return n;
  endfunction

endpackage

// Bit address to byte address and bit index
module bcc_bitmap
(
  // Bit address in
  input  wire logic [7:0] bit_addr,
  // Byte location out
  output logic      [7:0] byte_addr,
  output logic      [2:0] bit_idx
);

  // Low half packs into RAM bytes, high half sits in register bytes
  always_comb
  begin
    bit_idx = bit_addr[2:0];
    if (bit_addr < bcc_pkg::BIT_SFR_LIMIT)
      byte_addr = bcc_pkg::BIT_RAM_BASE + {4'h0, bit_addr[6:3]};
    else
      byte_addr = {bit_addr[7:3], 3'b000};
  end

endmodule

// ### hw/bcc_exec.sv
// Executer for carry-AND, compare-branch and clear instructions
`timescale 1ns/1ps

module bcc_exec
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Instruction hand-off from fetch
  input  wire logic        start,
  input  wire logic [7:0]  opcode,
  input  wire logic [7:0]  opnd1,
  input  wire logic [7:0]  opnd2,
  input  wire logic [15:0] pc_in,
  output logic             claim,
  output logic             busy,
  output logic             done,
  // Core state in
  input  wire logic [7:0]  acc_in,
  input  wire logic        carry_in,
  input  wire logic [1:0]  bank_sel,
  // Data space read port, data one clock after rd_en
  output logic             rd_en,
  output logic [7:0]       rd_addr,
  output logic             rd_indirect,
  input  wire logic [7:0]  rd_data,
  // Data space write port
  output logic             wr_en,
  output logic [7:0]       wr_addr,
  output logic [7:0]       wr_data,
  // Core state updates
  output logic             acc_we,
  output logic [7:0]       acc_wdata,
  output logic             carry_we,
  output logic             carry_wdata,
  output logic             pc_we,
  output logic [15:0]      pc_wdata
);

  // Sequencer states, one-hot
  typedef enum logic [3:0]
  {
    ST_IDLE    = 4'b0001,
    ST_RD_ADDR = 4'b0010,
    ST_RD_DATA = 4'b0100,
    ST_WAIT    = 4'b1000
  } bcc_state_t;

  bcc_state_t      state_reg;
  bcc_state_t      state_next;
  bcc_pkg::bcc_op_t op_reg;
  bcc_pkg::bcc_op_t op_in;
  logic [7:0]      opc_reg;
  logic [7:0]      b1_reg;
  logic [7:0]      b2_reg;
  logic [15:0]     pc_reg;
  logic [7:0]      acc_reg;
  logic            carry_reg;
  logic [1:0]      bank_reg;
  logic [7:0]      data_reg;
  logic            ptr_phase_reg;
  logic            rd_valid_reg;
  logic [3:0]      mc_cnt_reg;
  logic [1:0]      mc_left_reg;
  logic            mc_tick;
  logic            commit;
  logic            needs_read;
  logic [7:0]      first_addr;
  logic [7:0]      bit_byte;
  logic [2:0]      bit_idx;
  logic [7:0]      cmp_a;
  logic [7:0]      cmp_b;
  logic            src_bit;
  logic [15:0]     pc_seq;
  logic [15:0]     pc_next;
  logic            carry_next;
  logic            carry_we_next;

  // Decode of the offered opcode
  assign op_in = bcc_pkg::bcc_decode(opcode);
  assign claim = (op_in != bcc_pkg::BCC_OP_NONE);
  assign busy  = (state_reg != ST_IDLE);

  // Bit operand location from the second instruction byte
  bcc_bitmap u_bitmap
  (
    .bit_addr  (b1_reg),
    .byte_addr (bit_byte),
    .bit_idx   (bit_idx)
  );

  // First read address per operand form
  always_comb
  begin
    needs_read = 1'b1;
    first_addr = b1_reg;
    unique case (op_reg)
      bcc_pkg::BCC_OP_AND_BIT,
      bcc_pkg::BCC_OP_AND_NBIT,
      bcc_pkg::BCC_OP_CLR_BIT:
        first_addr = bit_byte;
      bcc_pkg::BCC_OP_CJ_DIR:
        first_addr = b1_reg;
      bcc_pkg::BCC_OP_CJ_REG:
        first_addr = {3'b000, bank_reg, opc_reg[2:0]};
      bcc_pkg::BCC_OP_CJ_IND:
        first_addr = {3'b000, bank_reg, 2'b00, opc_reg[0]};
      default:
        needs_read = 1'b0;
    endcase
  end

  // Machine-cycle divider, restarted by each accepted instruction
  always_ff @(posedge sys_clk)
  begin
    if (rst || (state_reg == ST_IDLE))
      mc_cnt_reg <= 4'h0;
    else if (mc_cnt_reg == bcc_pkg::MC_LAST)
      mc_cnt_reg <= 4'h0;
    else
      mc_cnt_reg <= mc_cnt_reg + 4'h1;
  end

  assign mc_tick = (mc_cnt_reg == bcc_pkg::MC_LAST);

  // Remaining machine cycles of the running instruction
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      mc_left_reg <= 2'd0;
    else if (state_reg == ST_IDLE && start && claim)
      mc_left_reg <= bcc_pkg::bcc_cycles(op_in);
    else if (mc_tick && mc_left_reg != 2'd0)
      mc_left_reg <= mc_left_reg - 2'd1;
  end

  // Results land at the close of the last machine cycle
  assign commit = (state_reg == ST_WAIT) && mc_tick
                  && (mc_left_reg == 2'd1);

  // Sequencer next state
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:
        if (start && claim)
          state_next = ST_RD_ADDR;
      ST_RD_ADDR:
        if (needs_read)
          state_next = ST_RD_DATA;
        else
          state_next = ST_WAIT;
      ST_RD_DATA:
        if (!rd_valid_reg)
          state_next = ST_RD_DATA;
        else if (op_reg == bcc_pkg::BCC_OP_CJ_IND && !ptr_phase_reg)
          state_next = ST_RD_DATA;
        else
          state_next = ST_WAIT;
      ST_WAIT:
        if (commit)
          state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  // Capture of the instruction and core state at hand-off
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      op_reg    <= bcc_pkg::BCC_OP_NONE;
      opc_reg   <= bcc_pkg::BYTE_RST;
      b1_reg    <= bcc_pkg::BYTE_RST;
      b2_reg    <= bcc_pkg::BYTE_RST;
      pc_reg    <= bcc_pkg::PC_RST;
      acc_reg   <= bcc_pkg::BYTE_RST;
      carry_reg <= 1'b0;
      bank_reg  <= 2'b00;
    end
    else if (state_reg == ST_IDLE && start && claim)
    begin
      op_reg    <= op_in;
      opc_reg   <= opcode;
      b1_reg    <= opnd1;
      b2_reg    <= opnd2;
      pc_reg    <= pc_in;
      acc_reg   <= acc_in;
      carry_reg <= carry_in;
      bank_reg  <= bank_sel;
    end
  end

  // Read port; the pointer form reads twice, pointer then RAM byte
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rd_en         <= 1'b0;
      rd_addr       <= bcc_pkg::BYTE_RST;
      rd_indirect   <= 1'b0;
      ptr_phase_reg <= 1'b0;
      rd_valid_reg  <= 1'b0;
    end
    else
    begin
      // Read data stands one clock after the strobe
      rd_valid_reg <= rd_en;
      rd_en       <= 1'b0;
      rd_indirect <= 1'b0;
      if (state_reg == ST_IDLE)
        ptr_phase_reg <= 1'b0;
      if (state_reg == ST_RD_ADDR && needs_read)
      begin
        rd_en   <= 1'b1;
        rd_addr <= first_addr;
      end
      else if (state_reg == ST_RD_DATA && rd_valid_reg
               && op_reg == bcc_pkg::BCC_OP_CJ_IND && !ptr_phase_reg)
      begin
        // Indirect fetch must hit RAM, never the register space
        rd_en         <= 1'b1;
        rd_addr       <= rd_data;
        rd_indirect   <= 1'b1;
        ptr_phase_reg <= 1'b1;
      end
    end
  end

  // Operand byte latched when its read returns
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      data_reg <= bcc_pkg::BYTE_RST;
    else if (state_reg == ST_RD_DATA && rd_valid_reg)
      data_reg <= rd_data;
  end

  // Compare operand selection for the four pairings
  always_comb
  begin
    cmp_a = acc_reg;
    cmp_b = b1_reg;
    unique case (op_reg)
      bcc_pkg::BCC_OP_CJ_DIR:
        cmp_b = data_reg;
      bcc_pkg::BCC_OP_CJ_REG,
      bcc_pkg::BCC_OP_CJ_IND:
        cmp_a = data_reg;
      default:
        cmp_b = b1_reg;
    endcase
  end

  assign src_bit = data_reg[bit_idx];

  // Sequential PC, past the whole instruction
  assign pc_seq = pc_reg + {14'h0000, bcc_pkg::bcc_len(op_reg)};

  // Result computation per operation
  always_comb
  begin
    pc_next       = pc_seq;
    carry_next    = carry_reg;
    carry_we_next = 1'b0;
    unique case (op_reg)
      bcc_pkg::BCC_OP_AND_BIT:
      begin
        carry_we_next = 1'b1;
        carry_next    = carry_reg & src_bit;
      end
      bcc_pkg::BCC_OP_AND_NBIT:
      begin
        carry_we_next = 1'b1;
        carry_next    = carry_reg & ~src_bit;
      end
      bcc_pkg::BCC_OP_CJ_DIR,
      bcc_pkg::BCC_OP_CJ_IMM,
      bcc_pkg::BCC_OP_CJ_REG,
      bcc_pkg::BCC_OP_CJ_IND:
      begin
        carry_we_next = 1'b1;
        carry_next    = (cmp_a < cmp_b);
        if (cmp_a != cmp_b)
          pc_next = pc_seq + {{8{b2_reg[7]}}, b2_reg};
      end
      bcc_pkg::BCC_OP_CLR_C:
      begin
        carry_we_next = 1'b1;
        carry_next    = 1'b0;
      end
      default:
        carry_we_next = 1'b0;
    endcase
  end

  // Core state updates, one-cycle strobes with held data
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      done        <= 1'b0;
      pc_we       <= 1'b0;
      pc_wdata    <= bcc_pkg::PC_RST;
      carry_we    <= 1'b0;
      carry_wdata <= 1'b0;
      acc_we      <= 1'b0;
      acc_wdata   <= bcc_pkg::BYTE_RST;
    end
    else
    begin
      done     <= commit;
      pc_we    <= commit;
      carry_we <= commit && carry_we_next;
      acc_we   <= commit && (op_reg == bcc_pkg::BCC_OP_CLR_A);
      if (commit)
      begin
        pc_wdata    <= pc_next;
        carry_wdata <= carry_next;
        acc_wdata   <= bcc_pkg::BYTE_RST;
      end
    end
  end

  // Bit clear is a read-modify-write of the holding byte
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wr_en   <= 1'b0;
      wr_addr <= bcc_pkg::BYTE_RST;
      wr_data <= bcc_pkg::BYTE_RST;
    end
    else
    begin
      wr_en <= commit && (op_reg == bcc_pkg::BCC_OP_CLR_BIT);
      if (commit)
      begin
        wr_addr <= bit_byte;
        wr_data <= data_reg & ~(8'h01 << bit_idx);
      end
    end
  end

endmodule

// ### sim/bcc_exec_monitor.sv
// Port checker for the instruction executer
`timescale 1ns/1ps
module bcc_exec_mon
(
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // Hand-off and core state
  input wire logic        start,
  input wire logic [7:0]  opcode,
  input wire logic [7:0]  opnd1,
  input wire logic [7:0]  opnd2,
  input wire logic [15:0] pc_in,
  input wire logic        claim,
  input wire logic        busy,
  input wire logic        done,
  input wire logic [7:0]  acc_in,
  input wire logic [1:0]  bank_sel,
  // Effects
  input wire logic        rd_en,
  input wire logic [7:0]  rd_addr,
  input wire logic        rd_indirect,
  input wire logic        wr_en,
  input wire logic        acc_we,
  input wire logic [7:0]  acc_wdata,
  input wire logic        carry_we,
  input wire logic        carry_wdata,
  input wire logic        pc_we,
  input wire logic [15:0] pc_wdata
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic        go;
  logic        two;
  logic [7:0]  k_opc;
  logic [7:0]  k_acc;
  logic [7:0]  k_imm;
  logic [7:0]  k_rel;
  logic [1:0]  k_bank;
  logic [15:0] k_pc;
  // Take and two-cycle decode
  assign go = start && claim && !busy;
  assign two = opcode inside {8'h82, 8'hB0, 8'hB4, 8'hB5, 8'hB6, 8'hB7}
               || opcode[7:3] == 5'h17;
  // Snapshot kept until the next take, since inputs may move meanwhile
  always_ff @(posedge sys_clk)
  begin
    if (go)
    begin
      k_opc  <= opcode;
      k_acc  <= acc_in;
      k_imm  <= opnd1;
      k_rel  <= opnd2;
      k_bank <= bank_sel;
      k_pc   <= pc_in;
    end
  end
  claim_decode_a:
    assert property (claim == (two || opcode inside {8'hE4, 8'hC3, 8'hC2}))
    else $error("claim wrong");
  long_time_a:
    assert property (go && two |-> ##25 done) else $error("late commit");
  short_time_a:
    assert property (go && !two |=> !done [*8] ##5 done)
    else $error("short commit");
  clr_acc_a:
    assert property (done && k_opc == 8'hE4 |-> acc_we && !carry_we
      && acc_wdata == 8'h00) else $error("acc clear");
  clr_carry_a:
    assert property (done && k_opc == 8'hC3 |-> carry_we && !carry_wdata
      && !acc_we && !wr_en) else $error("carry clear");
  imm_carry_a:
    assert property (done && k_opc == 8'hB4 |-> carry_we
      && carry_wdata == (k_acc < k_imm)) else $error("compare carry");
  imm_target_a:
    assert property (done && k_opc == 8'hB4 |-> pc_we && pc_wdata == k_pc
      + 16'h0003 + (k_acc != k_imm ? {{8{k_rel[7]}}, k_rel} : 16'h0000))
    else $error("branch target");
  reg_read_a:
    assert property (go && opcode[7:3] == 5'h17 |-> ##2 rd_en
      && rd_addr == {3'b000, k_bank, k_opc[2:0]}) else $error("reg read");
  ptr_read_a:
    assert property (go && opcode[7:1] == 7'h5B |-> ##2 rd_en && !rd_indirect
      ##2 rd_en && rd_indirect) else $error("pointer read");
  bit_map_a:
    assert property (go && opcode == 8'h82 |-> ##2 rd_en && rd_addr == (k_imm[7]
      ? k_imm & 8'hF8 : 8'h20 + {4'h0, k_imm[6:3]})) else $error("bit map");
  nbit_keep_a:
    assert property (done && k_opc == 8'hB0 |-> !wr_en && carry_we)
    else $error("source bit written");
  dir_commit_a:
    assert property (done && k_opc == 8'hB5 |-> pc_we && !wr_en && !acc_we)
    else $error("direct compare");
endmodule

bind bcc_exec bcc_exec_mon bcc_exec_mon_inst (.sys_clk, .rst, .start, .opcode,
  .opnd1, .opnd2, .pc_in, .claim, .busy, .done, .acc_in, .bank_sel, .rd_en,
  .rd_addr, .rd_indirect, .wr_en, .acc_we, .acc_wdata, .carry_we,
  .carry_wdata, .pc_we, .pc_wdata);

// ### sim/test_bit_and_compare_clear_exec.sv
// Self-checking bench for the instruction executer
`timescale 1ns/1ps
module test_bit_and_compare_clear_exec;
  logic        sys_clk, rst, start, claim, busy, done, carry_in;
  logic [7:0]  opcode, opnd1, opnd2, acc_in, rd_addr, rd_data, rd_last;
  logic [7:0]  wr_addr, wr_data, acc_wdata;
  logic [15:0] pc_in, pc_wdata;
  logic [1:0]  bank_sel;
  logic        rd_en, rd_indirect, rd_pend, wr_en, acc_we;
  logic        carry_we, carry_wdata, pc_we;
  logic [7:0]  mem [256];
  int          num_errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;

  bcc_exec bcc_exec_inst (.*);

  // Clock
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Data space: answers one clock late, toggles when idle
  always @(posedge sys_clk)
  begin
    rd_pend <= rd_en;
    rd_last <= rd_addr;
  end
  always @(negedge sys_clk)
    rd_data <= rd_pend ? mem[rd_last] : ~rd_data;

  // Hang guard, far above the few hundred cycles needed
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      num_errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Offer one instruction; ends on the done cycle, one after commit, so the next can follow
  task automatic run(input logic [7:0] op, a, b, acc, input int n,
                     input logic [3:0] fl, input logic [15:0] epc, wd);
    int k;
    opcode = op;
    opnd1 = a;
    opnd2 = b;
    acc_in = acc;
    start = 1'b1;
    @(negedge sys_clk);
    start = 1'b0;
    k = 1;
    while (done !== 1'b1 && k < 40)
    begin
      @(negedge sys_clk);
      k++;
    end
    chk(24'(k), 24'(12 * n + 1));
    chk({acc_we, carry_we, carry_we & carry_wdata, wr_en}, fl);
    chk({pc_we, pc_wdata}, {1'b1, epc});
    if (fl[0])
      chk({wr_addr, wr_data}, wd);
    if (fl[3])
      chk(acc_wdata, 8'h00);
  endtask

  task automatic t_carry_and();
    mem[8'h24] = 8'h08;
    mem[8'hE0] = 8'h7F;
    carry_in = 1'b1;
    run(8'h82, 8'h23, 8'h00, 8'h00, 2, 4'b0110, 16'h1000, 0);
    run(8'hB0, 8'h23, 8'h00, 8'h00, 2, 4'b0100, 16'h1000, 0);
    run(8'hB0, 8'hE7, 8'h00, 8'h00, 2, 4'b0110, 16'h1000, 0);
    run(8'h82, 8'h22, 8'h00, 8'h00, 2, 4'b0100, 16'h1000, 0);
    carry_in = 1'b0;
    run(8'h82, 8'h23, 8'h00, 8'h00, 2, 4'b0100, 16'h1000, 0);
    $display("carry and test done");
  endtask

  task automatic t_compare();
    bank_sel = 2'b10;
    mem[8'h40] = 8'h56;
    mem[8'h17] = 8'h56;
    mem[8'h11] = 8'h30;
    mem[8'h30] = 8'hA0;
    mem[8'h10] = 8'h31;
    mem[8'h31] = 8'h01;
    run(8'hB5, 8'h40, 8'h10, 8'h34, 2, 4'b0110, 16'h1011, 0);
    run(8'hB4, 8'h5A, 8'h10, 8'h5A, 2, 4'b0100, 16'h1001, 0);
    run(8'hB4, 8'h7F, 8'h80, 8'h80, 2, 4'b0100, 16'h0F81, 0);
    run(8'hBF, 8'h60, 8'hFE, 8'h00, 2, 4'b0110, 16'h0FFF, 0);
    run(8'hB7, 8'hA0, 8'h10, 8'h00, 2, 4'b0100, 16'h1001, 0);
    run(8'hB6, 8'h02, 8'h05, 8'h00, 2, 4'b0110, 16'h1006, 0);
    $display("compare test done");
  endtask

  task automatic t_clear();
    mem[8'h21] = 8'hFF;
    mem[8'h90] = 8'hAA;
    carry_in = 1'b1;
    run(8'hE4, 8'h00, 8'h00, 8'hA5, 1, 4'b1000, 16'h0FFF, 0);
    run(8'hC3, 8'h00, 8'h00, 8'hA5, 1, 4'b0100, 16'h0FFF, 0);
    run(8'hC2, 8'h0F, 8'h00, 8'hA5, 1, 4'b0001, 16'h1000, 16'h217F);
    run(8'hC2, 8'h93, 8'h00, 8'hA5, 1, 4'b0001, 16'h1000, 16'h90A2);
    $display("clear test done");
  endtask

  task automatic t_refuse();
    opcode = 8'h74;
    start = 1'b1;
    repeat (3) @(negedge sys_clk);
    start = 1'b0;
    chk({claim, busy, done}, 0);
    $display("refuse test done");
  endtask

  // Main sequence
  initial
  begin
    rst = 1'b1;
    start = 1'b0;
    opcode = 8'h00;
    opnd1 = 8'h00;
    opnd2 = 8'h00;
    acc_in = 8'h00;
    carry_in = 1'b0;
    bank_sel = 2'b00;
    pc_in = 16'h0FFE;
    rd_data = 8'h00;
    rd_pend = 1'b0;
    repeat (16) @(negedge sys_clk);
    chk({busy, done, pc_we, wr_en}, 0);
    rst = 1'b0;
    t_carry_and();
    t_compare();
    t_clear();
    t_refuse();
    complete_run();
  end
endmodule
